// ---- lpt_top.sv ----
// lcd panel timing and pixel path with its axi4-lite register slave
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module lpt_top #(
  parameter int FIFO_DEPTH = lpt_pkg::LPT_FIFO_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [lpt_pkg::LPT_AXI_AW-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [lpt_pkg::LPT_AXI_AW-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic controller_functional_clock_in,
  input wire logic [lpt_pkg::LPT_WORD-1:0] dma_data_in,
  input wire logic dma_frame_sync_in,
  input wire logic dma_valid_in,
  output logic dma_ready_out,
  output logic [15:0] panel_data_lines_out,
  output logic panel_pixel_clock_out,
  output logic panel_line_clock_out,
  output logic panel_frame_clock_out,
  output logic panel_bias_or_output_enable_out
);
  import lpt_pkg::*;
  lpt_st_t s_q;
  lpt_st_t s_d;
  logic tick;
  logic fall;
  logic act;
  logic mono;
  logic en;
  logic aw_go;
  logic ar_go;
  logic pop_go;
  logic pal_last;
  logic [2:0] bppn;
  logic [4:0] ow;
  logic [4:0] nb;
  logic [4:0] ppw_m1;
  logic [5:0] room;
  logic [6:0] len16;
  logic [10:0] len;
  logic [15:0] raw;
  logic [15:0] px;
  logic [11:0] rgb;
  logic [3:0] cr;
  logic [3:0] cg;
  logic [3:0] cb;
  logic [31:0] rd_val;
  logic rd_hit;

  lpt_fifo_if #(.WIDTH(LPT_WORD + 1)) fifo_bus ();

  // sync bit rides above each 16-bit word
  assign fifo_bus.push_valid = dma_valid_in;
  assign fifo_bus.push_data = {dma_frame_sync_in, dma_data_in};
  assign dma_ready_out = fifo_bus.push_ready;
  assign fifo_bus.pop_ready = pop_go;

  lpt_fifo #(.WIDTH(LPT_WORD + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .fifo_io(fifo_bus.store)
  );

  function automatic logic [15:0] lpt_pick(input logic [15:0] w, input logic [2:0] code, input logic [4:0] k);
    logic [15:0] r;
    r = w;
    // leftmost pixel sits in the byte's top bits
    case (code)
      LPT_BPP1: r = {15'h0000, w[{k[3], ~k[2:0]}]};
      LPT_BPP2: r = (w >> {k[2], ~k[1:0], 1'b0}) & 16'h0003;
      LPT_BPP4: r = (w >> {k[1], ~k[0], 2'h0}) & 16'h000F;
      LPT_BPP8: r = (w >> {k[0], 3'h0}) & 16'h00FF;
      default: r = w;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] lpt_expand(input logic [11:0] c);
    return {c[11:8], c[11], c[7:4], c[7:6], c[3:0], c[3]};
  endfunction

  function automatic logic [31:0] lpt_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign aw_go = s_axi_awvalid_in && s_axi_wvalid_in && !s_q.bvalid;
  assign ar_go = s_axi_arvalid_in && !s_q.rvalid;
  assign s_axi_awready_out = aw_go;
  assign s_axi_wready_out = aw_go;
  assign s_axi_arready_out = ar_go;
  assign s_axi_bvalid_out = s_q.bvalid;
  assign s_axi_bresp_out = s_q.bresp;
  assign s_axi_rvalid_out = s_q.rvalid;
  assign s_axi_rresp_out = s_q.rresp;
  assign s_axi_rdata_out = s_q.rdata;

  // narrower modes leave the upper lines at zero
  assign panel_data_lines_out = s_q.data;
  assign panel_pixel_clock_out = s_q.pclk;
  // line and frame clocks double as syncs
  assign panel_line_clock_out = s_q.lclk;
  assign panel_frame_clock_out = s_q.fclk;
  assign panel_bias_or_output_enable_out = act ? s_q.slot : s_q.acb;

  assign en = s_q.ctrl[LPT_CTRL_EN];
  assign act = s_q.ctrl[LPT_CTRL_ACTIVE];
  assign mono = s_q.ctrl[LPT_CTRL_MONO] && !act;
  assign len16 = {1'b0, s_q.timh[LPT_TIMH_PPL +: 6]} + 7'h01;
  assign len = {len16, 4'h0};

  always_comb
  begin
    ow = act ? 5'h10 : (mono ? 5'h04 : 5'h08);
    case (s_q.pixel_depth_code)
      LPT_BPP1: ppw_m1 = 5'h0F;
      LPT_BPP2: ppw_m1 = 5'h07;
      LPT_BPP4: ppw_m1 = 5'h03;
      LPT_BPP8: ppw_m1 = 5'h01;
      default: ppw_m1 = 5'h00;
    endcase
    raw = lpt_pick(s_q.word, s_q.pixel_depth_code, s_q.widx);
    rgb = s_q.pixel_depth_code[2] ? raw[11:0] : s_q.pal[raw[7:0]];
    cr = rgb[11:8];
    cg = rgb[7:4];
    cb = rgb[3:0];
    // 16-bit 565 colour passive uses the top four bits of each channel
    if (s_q.pixel_depth_code[2] && s_q.ctrl[LPT_CTRL_S565])
    begin
      cr = raw[15:12];
      cg = raw[10:7];
      cb = raw[4:1];
    end
    if (act)
    begin
      nb = 5'h10;
      px = s_q.pixel_depth_code[2] ? raw : lpt_expand(rgb);
    end
    else if (mono)
    begin
      nb = 5'h01;
      // low four bits dithered over frames
      px = {15'h0000, rgb[3:0] > s_q.ph};
    end
    else
    begin
      nb = 5'h03;
      px = {13'h0000, cr > s_q.ph, cg > s_q.ph, cb > s_q.ph};
    end
  end

  always_comb
  begin
    s_d = s_q;
    pop_go = 1'b0;
    tick = 1'b0;
    bppn = s_q.pixel_depth_code;
    pal_last = 1'b0;
    room = 6'h00;
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    s_d.fck = {s_q.fck[1:0], controller_functional_clock_in};
    // divide rising edges of the functional clock
    if (s_q.fck[1] && !s_q.fck[2])
    begin
      if (s_q.div == 8'h00)
      begin
        tick = 1'b1;
        s_d.div = s_q.timw[LPT_TIMW_DIV +: 8];
      end
      else
      begin
        s_d.div = s_q.div - 8'h01;
      end
    end
    fall = tick && s_q.hph;
    if (tick)
    begin
      s_d.hph = !s_q.hph;
    end
    if (fall)
    begin
      s_d.slot = 1'b0;
    end
    case (s_q.st)
      LPT_ST_IDLE:
      begin
        if (en && fifo_bus.pop_valid)
        begin
          if (!fifo_bus.pop_data[LPT_WORD])
          begin
            // discard until a frame start word
            pop_go = 1'b1;
          end
          else if (s_q.ctrl[LPT_CTRL_PLM +: 2] != LPT_PLM_DATA_ONLY)
          begin
            s_d.st = LPT_ST_PAL;
          end
          else
          begin
            s_d.st = LPT_ST_HBP;
            s_d.wcnt = s_q.timh[LPT_TIMH_HBP +: 8];
            s_d.x = 11'h000;
            // passive frame clock over the first line
            s_d.fclk = !act;
          end
        end
      end
      LPT_ST_PAL:
      begin
        if (fifo_bus.pop_valid)
        begin
          pop_go = 1'b1;
          if (s_q.pal_cnt == 8'h00)
          begin
            bppn = fifo_bus.pop_data[14:12];
            s_d.pixel_depth_code = bppn;
          end
          s_d.pal[s_q.pal_cnt] = fifo_bus.pop_data[11:0];
          s_d.pal_cnt = s_q.pal_cnt + 8'h01;
          pal_last = s_q.pal_cnt == ((bppn == LPT_BPP8) ? LPT_PAL_LAST_BIG : LPT_PAL_LAST_SMALL);
          if (pal_last)
          begin
            s_d.pal_cnt = 8'h00;
            s_d.ctrl[LPT_CTRL_PLM +: 2] = LPT_PLM_DATA_ONLY;
            if (s_q.ctrl[LPT_CTRL_PLM +: 2] == LPT_PLM_PAL_ONLY)
            begin
              s_d.st = LPT_ST_IDLE;
            end
            else
            begin
              s_d.st = LPT_ST_HBP;
              s_d.wcnt = s_q.timh[LPT_TIMH_HBP +: 8];
              s_d.x = 11'h000;
              s_d.fclk = !act;
            end
          end
        end
      end
      LPT_ST_HBP:
      begin
        if (fall)
        begin
          if (s_q.wcnt == 8'h00)
          begin
            s_d.st = LPT_ST_PIX;
          end
          else
          begin
            s_d.wcnt = s_q.wcnt - 8'h01;
          end
        end
      end
      LPT_ST_PIX:
      begin
        if (fall)
        begin
          if (s_q.acc_n >= {1'b0, ow})
          begin
            s_d.data = 16'((s_q.acc >> (s_q.acc_n - {1'b0, ow})) & ((32'h0000_0001 << ow) - 32'h0000_0001));
            s_d.acc_n = s_q.acc_n - {1'b0, ow};
            s_d.slot = 1'b1;
          end
          // line ends after every pixel left
          else if (s_q.acc_n == 6'h00 && s_q.x == len)
          begin
            s_d.st = LPT_ST_HFP;
            s_d.wcnt = s_q.timh[LPT_TIMH_HFP +: 8];
          end
        end
        room = 6'h20 - s_d.acc_n;
        if (!s_q.word_ok)
        begin
          if (fifo_bus.pop_valid)
          begin
            pop_go = 1'b1;
            s_d.word = fifo_bus.pop_data[15:0];
            s_d.word_ok = 1'b1;
            s_d.widx = 5'h00;
          end
        end
        else if (s_q.x != len && room >= {1'b0, nb})
        begin
          s_d.acc = (s_q.acc << nb) | {16'h0000, px};
          s_d.acc_n = s_d.acc_n + {1'b0, nb};
          s_d.x = s_q.x + 11'h001;
          s_d.pixtot = s_q.pixtot + 21'h000001;
          s_d.word_ok = s_q.widx != ppw_m1;
          s_d.widx = s_q.widx + 5'h01;
        end
      end
      LPT_ST_HFP:
      begin
        if (fall)
        begin
          if (s_q.wcnt == 8'h00)
          begin
            s_d.st = LPT_ST_LCLK;
            s_d.lclk = 1'b1;
          end
          else
          begin
            s_d.wcnt = s_q.wcnt - 8'h01;
          end
        end
      end
      LPT_ST_LCLK:
      begin
        if (fall)
        begin
          s_d.lclk = 1'b0;
          s_d.line = s_q.line + 10'h001;
          if (!act)
          begin
            s_d.fclk = 1'b0;
          end
          // frame ends when the total pixel count is reached
          if (s_q.pixtot >= s_q.timv[LPT_TIMV_TOTAL +: 21])
          begin
            s_d.st = LPT_ST_VWAIT;
            s_d.wcnt = s_q.timw[LPT_TIMW_VWAIT +: 8];
          end
          else
          begin
            s_d.st = LPT_ST_HBP;
            s_d.wcnt = s_q.timh[LPT_TIMH_HBP +: 8];
            s_d.x = 11'h000;
          end
        end
      end
      LPT_ST_VWAIT:
      begin
        if (fall)
        begin
          if (s_q.lclk)
          begin
            s_d.lclk = 1'b0;
            s_d.wcnt = s_q.wcnt - 8'h01;
          end
          else if (s_q.wcnt != 8'h00)
          begin
            s_d.lclk = 1'b1;
          end
          // active frame clock after the waits
          else if (act)
          begin
            s_d.st = LPT_ST_VSYNC;
            s_d.fclk = 1'b1;
          end
          else
          begin
            s_d.st = LPT_ST_IDLE;
          end
        end
      end
      LPT_ST_VSYNC:
      begin
        if (fall)
        begin
          s_d.fclk = 1'b0;
          s_d.st = LPT_ST_IDLE;
        end
      end
      default:
      begin
        s_d.st = LPT_ST_IDLE;
      end
    endcase
    // frame wrap-up and dither phase step
    if (s_d.st == LPT_ST_IDLE && s_q.st != LPT_ST_IDLE)
    begin
      s_d.line = 10'h000;
      s_d.pixtot = 21'h000000;
      s_d.ph = (s_q.ph == LPT_DITHER_LAST) ? 4'h0 : s_q.ph + 4'h1;
    end
    // bias inverts every programmed count of line clocks
    if (s_d.lclk && !s_q.lclk && !act && s_q.ctrl[LPT_CTRL_ACMODE])
    begin
      s_d.ac_cnt = s_q.ac_cnt + 8'h01;
      if (s_d.ac_cnt == s_q.timw[LPT_TIMW_ACCNT +: 8])
      begin
        s_d.ac_cnt = 8'h00;
        s_d.acb = !s_q.acb;
      end
    end
    // no passive pixel clock outside data slots
    if (tick)
    begin
      s_d.pclk = s_d.hph && (act || s_d.slot);
    end
    if (!en)
    begin
      s_d.st = LPT_ST_IDLE;
      s_d.x = 11'h000;
      s_d.line = 10'h000;
      s_d.pixtot = 21'h000000;
      s_d.acc_n = 6'h00;
      s_d.word_ok = 1'b0;
      s_d.pal_cnt = 8'h00;
      s_d.ac_cnt = 8'h00;
      s_d.lclk = 1'b0;
      s_d.fclk = 1'b0;
      s_d.pclk = 1'b0;
      s_d.slot = 1'b0;
      s_d.data = 16'h0000;
    end
    // register writes, software last
    if (aw_go)
    begin
      s_d.bvalid = 1'b1;
      s_d.bresp = LPT_RESP_OK;
      case (s_axi_awaddr_in)
        LPT_OFS_CTRL: s_d.ctrl = lpt_merge(s_d.ctrl, s_axi_wdata_in, s_axi_wstrb_in);
        LPT_OFS_TIMH: s_d.timh = lpt_merge(s_q.timh, s_axi_wdata_in, s_axi_wstrb_in);
        LPT_OFS_TIMV: s_d.timv = lpt_merge(s_q.timv, s_axi_wdata_in, s_axi_wstrb_in);
        LPT_OFS_TIMW: s_d.timw = lpt_merge(s_q.timw, s_axi_wdata_in, s_axi_wstrb_in);
        LPT_OFS_STAT: s_d.bresp = LPT_RESP_OK;
        default: s_d.bresp = LPT_RESP_SLVERR;
      endcase
    end
    else if (s_q.bvalid && s_axi_bready_in)
    begin
      s_d.bvalid = 1'b0;
    end
    case (s_axi_araddr_in)
      LPT_OFS_CTRL: rd_val = s_q.ctrl;
      LPT_OFS_TIMH: rd_val = s_q.timh;
      LPT_OFS_TIMV: rd_val = s_q.timv;
      LPT_OFS_TIMW: rd_val = s_q.timw;
      LPT_OFS_STAT:
      begin
        rd_val[9:0] = s_q.line;
        rd_val[LPT_STAT_BPP +: 3] = s_q.pixel_depth_code;
        rd_val[LPT_STAT_BUSY] = s_q.st != LPT_ST_IDLE;
      end
      default: rd_hit = 1'b0;
    endcase
    if (ar_go)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_val;
      s_d.rresp = rd_hit ? LPT_RESP_OK : LPT_RESP_SLVERR;
    end
    else if (s_q.rvalid && s_axi_rready_in)
    begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      s_q <= '0;
      s_q.ctrl <= LPT_CTRL_RST;
      s_q.timh <= LPT_TIMH_RST;
      s_q.timv <= LPT_TIMV_RST;
      s_q.timw <= LPT_TIMW_RST;
      s_q.st <= LPT_ST_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule

// ---- lpt_pkg.sv ----
// constants and state types for the lcd panel timing pixel path
package lpt_pkg;
  localparam int LPT_AXI_AW = 5;
  localparam logic [4:0] LPT_OFS_CTRL = 5'h00;
  localparam logic [4:0] LPT_OFS_TIMH = 5'h04;
  localparam logic [4:0] LPT_OFS_TIMV = 5'h08;
  localparam logic [4:0] LPT_OFS_TIMW = 5'h0C;
  localparam logic [4:0] LPT_OFS_STAT = 5'h10;
  localparam int LPT_CTRL_EN = 0;
  localparam int LPT_CTRL_ACTIVE = 1;
  localparam int LPT_CTRL_MONO = 2;
  localparam int LPT_CTRL_S565 = 3;
  localparam int LPT_CTRL_PLM = 4;
  localparam int LPT_CTRL_ACMODE = 6;
  localparam int LPT_TIMH_PPL = 0;
  localparam int LPT_TIMH_HBP = 8;
  localparam int LPT_TIMH_HFP = 16;
  localparam int LPT_TIMV_TOTAL = 0;
  localparam int LPT_TIMW_VWAIT = 0;
  localparam int LPT_TIMW_ACCNT = 8;
  localparam int LPT_TIMW_DIV = 16;
  localparam int LPT_STAT_BPP = 12;
  localparam int LPT_STAT_BUSY = 16;
  localparam logic [31:0] LPT_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] LPT_TIMH_RST = 32'h0000_0000;
  localparam logic [31:0] LPT_TIMV_RST = 32'h0000_0100;
  localparam logic [31:0] LPT_TIMW_RST = 32'h0001_0000;
  localparam logic [1:0] LPT_PLM_BOTH = 2'h0;
  localparam logic [1:0] LPT_PLM_PAL_ONLY = 2'h1;
  localparam logic [1:0] LPT_PLM_DATA_ONLY = 2'h2;
  localparam logic [2:0] LPT_BPP1 = 3'h0;
  localparam logic [2:0] LPT_BPP2 = 3'h1;
  localparam logic [2:0] LPT_BPP4 = 3'h2;
  localparam logic [2:0] LPT_BPP8 = 3'h3;
  localparam logic [7:0] LPT_PAL_LAST_SMALL = 8'h0F;
  localparam logic [7:0] LPT_PAL_LAST_BIG = 8'hFF;
  localparam logic [3:0] LPT_DITHER_LAST = 4'hE;
  localparam int LPT_WORD = 16;
  localparam int LPT_FIFO_DEPTH = 64;
  localparam logic [1:0] LPT_RESP_OK = 2'h0;
  localparam logic [1:0] LPT_RESP_SLVERR = 2'h2;
  typedef enum logic [7:0] {
    LPT_ST_IDLE = 8'h01,
    LPT_ST_PAL = 8'h02,
    LPT_ST_HBP = 8'h04,
    LPT_ST_PIX = 8'h08,
    LPT_ST_HFP = 8'h10,
    LPT_ST_LCLK = 8'h20,
    LPT_ST_VWAIT = 8'h40,
    LPT_ST_VSYNC = 8'h80
  } lpt_state_t;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] timh;
    logic [31:0] timv;
    logic [31:0] timw;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [2:0] fck;
    logic [7:0] div;
    logic hph;
    lpt_state_t st;
    logic [255:0][11:0] pal;
    logic [2:0] pixel_depth_code;
    logic [7:0] pal_cnt;
    logic [15:0] word;
    logic word_ok;
    logic [4:0] widx;
    logic [31:0] acc;
    logic [5:0] acc_n;
    logic [10:0] x;
    logic [20:0] pixtot;
    logic [9:0] line;
    logic [7:0] wcnt;
    logic [3:0] ph;
    logic pclk;
    logic lclk;
    logic fclk;
    logic acb;
    logic slot;
    logic [15:0] data;
    logic [7:0] ac_cnt;
  } lpt_st_t;
endpackage

// ---- lpt_fifo_if.sv ----
// interface between the pixel path and its input fifo
`timescale 1ns/1ps
interface lpt_fifo_if #(parameter int WIDTH = 17);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  modport store (input push_valid, input push_data, input pop_ready,
    output push_ready, output pop_valid, output pop_data);
  modport user (output push_valid, output push_data, output pop_ready,
    input push_ready, input pop_valid, input pop_data);
endinterface

// ---- lpt_fifo.sv ----
// input fifo of the pixel path, flip-flop storage
`timescale 1ns/1ps
module lpt_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 64
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  lpt_fifo_if.store fifo_io
);
  import lpt_pkg::*;
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } lpt_fifo_st_t;
  lpt_fifo_st_t s_q;
  lpt_fifo_st_t s_d;
  logic do_push;
  logic do_pop;

  assign fifo_io.push_ready = s_q.cnt != (AW + 1)'(DEPTH);
  assign fifo_io.pop_valid = s_q.cnt != '0;
  assign fifo_io.pop_data = s_q.mem[s_q.rd];
  assign do_push = fifo_io.push_valid && fifo_io.push_ready;
  assign do_pop = fifo_io.pop_ready && fifo_io.pop_valid;

  always_comb
  begin
    s_d = s_q;
    if (do_push)
    begin
      s_d.mem[s_q.wr] = fifo_io.push_data;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (do_pop)
    begin
      s_d.rd = s_q.rd + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule

// ---- lpt_properties.sv ----
// port checks for the lcd panel timing top
`timescale 1ns/1ps
module lpt_properties (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [15:0] panel_data_lines_out,
  input wire logic panel_pixel_clock_out,
  input wire logic panel_line_clock_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence wr_take;
    s_axi_awvalid_in && s_axi_wvalid_in && s_axi_awready_out;
  endsequence
  sequence rd_take;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  a_write_answer: assert property (wr_take |=> s_axi_bvalid_out) else $error("write not answered");
  a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  a_write_refused: assert property (s_axi_bvalid_out |-> !s_axi_awready_out) else $error("write taken while busy");
  a_read_answer: assert property (rd_take |=> s_axi_rvalid_out) else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
  a_read_refused: assert property (s_axi_rvalid_out |-> !s_axi_arready_out) else $error("read taken while busy");
  a_data_pclk_low: assert property (!$stable(panel_data_lines_out) |-> !panel_pixel_clock_out)
    else $error("data moved with pixel clock high");
  a_line_width: assert property ($rose(panel_line_clock_out) |-> panel_line_clock_out [*8])
    else $error("line clock pulse too short");
endmodule
bind lpt_top lpt_properties lpt_properties_i (.*);

// ---- lpt_panel_model.sv ----
// panel model: latches enabled pixels, counts line and frame clocks
`timescale 1ns/1ps
module lpt_panel_model (
  input wire logic panel_pixel_clock_in,
  input wire logic [15:0] panel_data_lines_in,
  input wire logic panel_bias_or_output_enable_in,
  input wire logic panel_line_clock_in,
  input wire logic panel_frame_clock_in
);
  logic [15:0] got[$];
  int lines = 0;
  int frames = 0;
  bit passive = 0;
  // latch on enable, or on every passive pixel clock
  always @(posedge panel_pixel_clock_in)
    if (passive || panel_bias_or_output_enable_in === 1'b1)
      got.push_back(panel_data_lines_in);
  always @(posedge panel_line_clock_in)
    lines++;
  always @(posedge panel_frame_clock_in)
    frames++;
endmodule

// ---- tb_lcd_panel_timing_pixel_path.sv ----
// self-checking bench for the lcd panel timing pixel path
`timescale 1ns/1ps
module tb_lcd_panel_timing_pixel_path;
  import lpt_pkg::*;
  logic ref_clk_in = 0, reset_n_in = 0, controller_functional_clock_in = 0;
  logic [4:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
  logic [31:0] s_axi_wdata_in = 0;
  logic [3:0] s_axi_wstrb_in = 4'hF;
  logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0, s_axi_arvalid_in = 0, s_axi_rready_in = 0;
  logic [15:0] dma_data_in = 0;
  logic dma_frame_sync_in = 0, dma_valid_in = 0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, dma_ready_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out;
  logic [15:0] panel_data_lines_out;
  logic panel_pixel_clock_out, panel_line_clock_out, panel_frame_clock_out, panel_bias_or_output_enable_out;
  int mismatches = 0, comparisons = 0, cycles = 0, seed = 37219, i, ph = 0;
  logic [31:0] regm [4];
  logic [31:0] msk [4] = '{32'h0, 32'h00FF_FF3F, 32'h001F_FFFF, 32'h00FF_FFFF};
  logic [15:0] exp_q[$];
  logic [11:0] pal [256];
  always #50 ref_clk_in = ~ref_clk_in;
  initial #137 forever #400 controller_functional_clock_in = ~controller_functional_clock_in;
  lpt_top lpt_top_i (.*);
  lpt_panel_model panel_i (.panel_pixel_clock_in(panel_pixel_clock_out), .panel_data_lines_in(panel_data_lines_out),
    .panel_bias_or_output_enable_in(panel_bias_or_output_enable_out), .panel_line_clock_in(panel_line_clock_out),
    .panel_frame_clock_in(panel_frame_clock_out));
  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge ref_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1;
    s_axi_wvalid_in <= 1;
    do @(negedge ref_clk_in); while (s_axi_awready_out !== 1'b1 || s_axi_wready_out !== 1'b1);
    @(posedge ref_clk_in);
    s_axi_awvalid_in <= 0;
    s_axi_wvalid_in <= 0;
    s_axi_bready_in <= 1;
    do @(negedge ref_clk_in); while (s_axi_bvalid_out !== 1'b1);
    chk({30'h0, s_axi_bresp_out}, {30'h0, r});
    @(posedge ref_clk_in);
    s_axi_bready_in <= 0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge ref_clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1;
    do @(negedge ref_clk_in); while (s_axi_arready_out !== 1'b1);
    @(posedge ref_clk_in);
    s_axi_arvalid_in <= 0;
    s_axi_rready_in <= 1;
    do @(negedge ref_clk_in); while (s_axi_rvalid_out !== 1'b1);
    chk(s_axi_rdata_out, d);
    chk({30'h0, s_axi_rresp_out}, {30'h0, r});
    @(posedge ref_clk_in);
    s_axi_rready_in <= 0;
  endtask
  task automatic push(input logic [15:0] w, input logic s);
    dma_data_in <= w;
    dma_frame_sync_in <= s;
    dma_valid_in <= 1;
    do @(negedge ref_clk_in); while (dma_ready_out !== 1'b1);
    @(posedge ref_clk_in);
  endtask
  function automatic logic [15:0] x565(input logic [11:0] c);
    return {c[11:8], c[11], c[7:4], c[7:6], c[3:0], c[3]};
  endfunction
  // one frame of 16 pixels: 0 active raw 16-bit, 1 active 8-bit palette, 2 passive mono 4-bit palette
  task automatic run(input int m);
    int k;
    logic [15:0] w;
    logic [2:0] bc;
    logic [31:0] c;
    exp_q.delete();
    panel_i.got.delete();
    panel_i.lines = 0;
    panel_i.frames = 0;
    panel_i.passive = (m == 2);
    bc = (m == 0) ? 3'h4 : ((m == 1) ? LPT_BPP8 : LPT_BPP4);
    c = (m == 2) ? 32'h5 : 32'h3;
    wr(LPT_OFS_CTRL, c, LPT_RESP_OK);
    for (k = 0; k < ((m == 1) ? 256 : 16); k++)
    begin
      pal[k] = (m == 0) ? 12'h0 : 12'($random(seed));
      push({1'b0, (k != 0) ? 3'h0 : bc, pal[k]}, k == 0);
    end
    for (k = 0; k < ((m == 2) ? 4 : ((m == 1) ? 8 : 16)); k++)
    begin
      w = 16'($random(seed));
      if (m == 0)
        exp_q.push_back(w);
      else if (m == 1)
      begin
        exp_q.push_back(x565(pal[w[7:0]]));
        exp_q.push_back(x565(pal[w[15:8]]));
      end
      else
        exp_q.push_back({12'h000, pal[w[7:4]][3:0] > ph, pal[w[3:0]][3:0] > ph, pal[w[15:12]][3:0] > ph,
          pal[w[11:8]][3:0] > ph});
      push(w, 1'b0);
    end
    dma_valid_in <= 0;
    wait (panel_i.lines != 0 && panel_i.frames != 0);
    // let the line clock and the frame tail finish before touching the block
    repeat (48) @(posedge ref_clk_in);
    chk(panel_i.lines, 1);
    chk(panel_i.frames, 1);
    chk(panel_i.got.size(), (m == 2) ? 4 : 16);
    foreach (exp_q[k]) chk({16'h0, panel_i.got[k]}, {16'h0, exp_q[k]});
    rd(LPT_OFS_STAT, {17'h0, bc, 12'h000}, LPT_RESP_OK);
    rd(LPT_OFS_CTRL, c | 32'h20, LPT_RESP_OK);
    wr(LPT_OFS_CTRL, 32'h0, LPT_RESP_OK);
    ph++;
  endtask
  initial
  begin
    regm = '{LPT_CTRL_RST, LPT_TIMH_RST, LPT_TIMV_RST, LPT_TIMW_RST};
    repeat (2) @(posedge ref_clk_in);
    reset_n_in <= 1;
    for (i = 0; i < 4; i++)
      rd(5'(i * 4), regm[i], LPT_RESP_OK);
    for (i = 1; i < 4; i++)
    begin
      regm[i] = $random(seed) & msk[i];
      wr(5'(i * 4), regm[i], LPT_RESP_OK);
      rd(5'(i * 4), regm[i], LPT_RESP_OK);
    end
    wr(5'h14, $random(seed), LPT_RESP_SLVERR);
    rd(5'h14, 32'h0, LPT_RESP_SLVERR);
    wr(LPT_OFS_STAT, $random(seed), LPT_RESP_OK);
    wr(LPT_OFS_TIMH, 32'h0, LPT_RESP_OK);
    wr(LPT_OFS_TIMV, 32'd16, LPT_RESP_OK);
    wr(LPT_OFS_TIMW, 32'h0, LPT_RESP_OK);
    run(0);
    run(1);
    run(2);
    print_verdict();
  end
endmodule
